//--- hw/fhb_host.sv
// Host controller driving the asynchronous pins of a block-erasable flash
//
// Contract
// - Host drives command or data on writes
// - Chip select low for any access
// - Wait 750 ns after reset release
// - Hold reset low through power transitions
// - Write strobe rising edge latches address, data
`timescale 1ns/100ps
module fhb_host #(
	parameter int WAKE_CYC = fhb_pkg::WAKE_CYC,
	parameter int ACCESS_CYC = fhb_pkg::ACCESS_CYC,
	parameter int STROBE_CYC = fhb_pkg::STROBE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// User side
	input wire logic req_valid_i,
	input wire fhb_pkg::fhb_req_s req_i,
	output logic req_ready_o,
	output logic rd_valid_o,
	output logic [fhb_pkg::DATA_W-1:0] rd_data_o,
	input wire logic powerdown_i,
	output logic busy_o,
	output logic awake_o,
	// Flash pins
	output logic [fhb_pkg::ADDR_W-1:0] addr_o,
	input wire logic [fhb_pkg::DATA_W-1:0] data_lines_i,
	output logic [fhb_pkg::DATA_W-1:0] data_lines_o,
	output logic data_lines_oe_o,
	output logic chip_sel_n_o,
	output logic out_en_n_o,
	output logic write_n_o,
	output logic reset_powerdown_n_o,
	input wire logic ready_busy_n_i
);
	////////////////////////////////////////////////////////////////////////////////
	// State and pin registers
	fhb_pkg::fhb_state_e state_q;
	fhb_pkg::fhb_state_e state_d;
	fhb_pkg::fhb_pins_s pins_q;
	fhb_pkg::fhb_pins_s pins_d;
	logic [fhb_pkg::DATA_W-1:0] rd_data_q;
	logic [fhb_pkg::DATA_W-1:0] rd_data_d;
	logic rd_valid_q;
	logic rd_valid_d;
	logic ready_q;
	logic ready_d;
	logic busy_q;
	logic awake_q;
	logic t_load;
	logic [fhb_pkg::CNT_W-1:0] t_count;
	logic t_done;

	// Cut an integer cycle count to the timer width
	function automatic logic [fhb_pkg::CNT_W-1:0] cyc(input int n);
		cyc = fhb_pkg::CNT_W'(n);
	endfunction : cyc

	// Join block and offset into the pin address
	function automatic logic [fhb_pkg::ADDR_W-1:0] join_addr(input fhb_pkg::fhb_req_s r);
		join_addr = {r.block, r.offset};
	endfunction : join_addr

	////////////////////////////////////////////////////////////////////////////////
	// Timing counter
	fhb_timer #(
		.CNT_W(fhb_pkg::CNT_W)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(t_load),
		.count_i(t_count),
		.done_o(t_done)
	);

	// Accept a request only in idle, while ready is shown, with no pending power-down
	wire take_req = (state_q == fhb_pkg::FHB_IDLE) && ready_q && req_valid_i && !powerdown_i;
	wire wake_req = (state_q == fhb_pkg::FHB_PWRDN) && !powerdown_i && t_done;

	////////////////////////////////////////////////////////////////////////////////
	// Next state, pins and timer loads
	always_comb begin
		state_d = state_q;
		pins_d = pins_q;
		rd_data_d = rd_data_q;
		rd_valid_d = 1'b0;
		ready_d = 1'b0;
		t_load = 1'b0;
		t_count = '0;
		case (state_q)
			fhb_pkg::FHB_PWRDN: begin
				// Reset held low; minimum low time before wake
				pins_d.reset_powerdown_n = 1'b0;
				pins_d.chip_sel_n = 1'b1;
				pins_d.out_en_n = 1'b1;
				pins_d.write_n = 1'b1;
				pins_d.dout_en = 1'b0;
				if (wake_req) begin
					pins_d.reset_powerdown_n = 1'b1;
					t_load = 1'b1;
					t_count = cyc(WAKE_CYC);
					state_d = fhb_pkg::FHB_WAKE;
				end
			end
			fhb_pkg::FHB_WAKE: begin
				// No access until the recovery time has run out
				if (t_done) begin
					ready_d = !req_valid_i;
					state_d = fhb_pkg::FHB_IDLE;
				end
			end
			fhb_pkg::FHB_IDLE: begin
				ready_d = 1'b1;
				if (powerdown_i) begin
					ready_d = 1'b0;
					pins_d.reset_powerdown_n = 1'b0;
					t_load = 1'b1;
					t_count = cyc(fhb_pkg::RESET_HOLD_CYC);
					state_d = fhb_pkg::FHB_PWRDN;
				end else if (take_req) begin
					ready_d = 1'b0;
					pins_d.addr = join_addr(req_i);
					pins_d.chip_sel_n = 1'b0;
					t_load = 1'b1;
					if (req_i.write) begin
						pins_d.out_en_n = 1'b1;
						pins_d.dout = req_i.wdata;
						pins_d.dout_en = 1'b1;
						pins_d.write_n = 1'b0;
						t_count = cyc(STROBE_CYC);
						state_d = fhb_pkg::FHB_WR;
					end else begin
						pins_d.dout_en = 1'b0;
						pins_d.out_en_n = 1'b0;
						t_count = cyc(ACCESS_CYC);
						state_d = fhb_pkg::FHB_RD;
					end
				end
			end
			fhb_pkg::FHB_RD: begin
				// Sample data after the access time, then release the bus
				if (t_done) begin
					rd_data_d = data_lines_i;
					rd_valid_d = 1'b1;
					pins_d.out_en_n = 1'b1;
					pins_d.chip_sel_n = 1'b1;
					t_load = 1'b1;
					t_count = cyc(fhb_pkg::HOLD_CYC);
					state_d = fhb_pkg::FHB_GAP;
				end
			end
			fhb_pkg::FHB_WR: begin
				// Rising strobe edge latches address and data
				if (t_done) begin
					pins_d.write_n = 1'b1;
					t_load = 1'b1;
					t_count = cyc(fhb_pkg::HOLD_CYC);
					state_d = fhb_pkg::FHB_WR_HOLD;
				end
			end
			fhb_pkg::FHB_WR_HOLD: begin
				// Keep address and data stable past the strobe edge
				if (t_done) begin
					pins_d.dout_en = 1'b0;
					pins_d.chip_sel_n = 1'b1;
					t_load = 1'b1;
					t_count = cyc(fhb_pkg::HOLD_CYC);
					state_d = fhb_pkg::FHB_GAP;
				end
			end
			fhb_pkg::FHB_GAP: begin
				// Bus turnaround before the next access
				if (t_done) begin
					ready_d = !powerdown_i;
					state_d = fhb_pkg::FHB_IDLE;
				end
			end
			default: begin
				state_d = fhb_pkg::FHB_PWRDN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers; reset starts with the flash held in reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= fhb_pkg::FHB_PWRDN;
			pins_q <= '{addr: '0, dout: '0, dout_en: 1'b0, chip_sel_n: 1'b1,
				out_en_n: 1'b1, write_n: 1'b1, reset_powerdown_n: 1'b0};
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
			ready_q <= 1'b0;
			busy_q <= 1'b0;
			awake_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pins_q <= pins_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			ready_q <= ready_d;
			busy_q <= !ready_busy_n_i && pins_q.reset_powerdown_n;
			awake_q <= (state_d == fhb_pkg::FHB_IDLE) || (state_d == fhb_pkg::FHB_RD)
				|| (state_d == fhb_pkg::FHB_WR) || (state_d == fhb_pkg::FHB_WR_HOLD)
				|| (state_d == fhb_pkg::FHB_GAP);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from registers
	assign addr_o = pins_q.addr;
	assign data_lines_o = pins_q.dout;
	assign data_lines_oe_o = pins_q.dout_en;
	assign chip_sel_n_o = pins_q.chip_sel_n;
	assign out_en_n_o = pins_q.out_en_n;
	assign write_n_o = pins_q.write_n;
	assign reset_powerdown_n_o = pins_q.reset_powerdown_n;
	assign rd_data_o = rd_data_q;
	assign rd_valid_o = rd_valid_q;
	assign req_ready_o = ready_q;
	assign busy_o = busy_q;
	assign awake_o = awake_q;
endmodule : fhb_host

//--- hw/fhb_pkg.sv
// Package: pin field layout, bus timing counts and carrier structs for the flash host
package fhb_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int BYTE_W = 14;
	localparam int BLOCK_W = 5;
	localparam int BLOCK_LSB = 14;
	localparam int NUM_BLOCKS = 32;
	localparam int CLK_PERIOD_NS = 10;
	// Recovery after deep power-down
	localparam int WAKE_NS = 750;
	localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Reset pulse held low, read access and write strobe widths
	localparam int RESET_HOLD_NS = 100;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_NS = 200;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_NS = 30;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;

	// User request toward the bus
	typedef struct packed {
		logic write;
		logic [BLOCK_W-1:0] block;
		logic [BYTE_W-1:0] offset;
		logic [DATA_W-1:0] wdata;
	} fhb_req_s;

	// Pins driven toward the flash
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic dout_en;
		logic chip_sel_n;
		logic out_en_n;
		logic write_n;
		logic reset_powerdown_n;
	} fhb_pins_s;

	typedef enum logic [2:0] {
		FHB_PWRDN,
		FHB_WAKE,
		FHB_IDLE,
		FHB_RD,
		FHB_WR,
		FHB_WR_HOLD,
		FHB_GAP
	} fhb_state_e;
endpackage : fhb_pkg

//--- hw/fhb_timer.sv
// Down-counter that signals when a programmed cycle count has elapsed
`timescale 1ns/100ps
module fhb_timer #(
	parameter int CNT_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [CNT_W-1:0] count_i,
	output logic done_o
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	// Load a fresh count or step toward zero
	assign cnt_d = load_i ? count_i : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
	assign done_o = (cnt_q == '0); // Depends on the count only, so a reload cannot loop back

	// Counter register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : fhb_timer

//--- test/fhb_host_properties.sv
// Assertions on the flash host pins
`timescale 1ns/100ps
module fhb_host_properties #(
	parameter int WAKE_CYC = fhb_pkg::WAKE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_valid_o,
	input wire logic [18:0] addr_o,
	input wire logic [7:0] data_lines_o,
	input wire logic data_lines_oe_o,
	input wire logic chip_sel_n_o,
	input wire logic out_en_n_o,
	input wire logic write_n_o,
	input wire logic reset_powerdown_n_o
);
	logic [7:0] up_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	// Cycles since the flash left power-down
	always_ff @(posedge clk_i) begin
		if (!reset_powerdown_n_o) begin
			up_q <= 8'h00;
		end else if (up_q != 8'hff) begin
			up_q <= up_q + 8'h01;
		end
	end
	// Pin relations
	reset_safe_a: assert property (
		$fell(rst_i) |-> !reset_powerdown_n_o && chip_sel_n_o)
		else $error("flash not held in reset");
	pd_quiet_a: assert property (
		!reset_powerdown_n_o |-> chip_sel_n_o && write_n_o && out_en_n_o)
		else $error("access in power-down");
	wake_wait_a: assert property (
		!chip_sel_n_o |-> up_q >= WAKE_CYC)
		else $error("access before recovery");
	addr_hold_a: assert property (
		!chip_sel_n_o && !$past(chip_sel_n_o) |-> $stable(addr_o))
		else $error("address moved in access");
	wr_drive_a: assert property (
		!write_n_o |-> data_lines_oe_o && out_en_n_o && !chip_sel_n_o)
		else $error("bad pins in write");
	rd_float_a: assert property (
		!out_en_n_o |-> !data_lines_oe_o && write_n_o && !chip_sel_n_o)
		else $error("bad pins in read");
	strobe_hold_a: assert property (
		$rose(write_n_o) |-> data_lines_oe_o && $stable(data_lines_o) ##1 data_lines_oe_o)
		else $error("data not held at strobe");
	rd_pulse_a: assert property (
		rd_valid_o |-> !$past(out_en_n_o) ##1 !rd_valid_o)
		else $error("read result out of place");
	// Main scenarios
	cover property (rd_valid_o);
	cover property ($rose(write_n_o));
	cover property ($fell(reset_powerdown_n_o));
endmodule : fhb_host_properties
bind fhb_host fhb_host_properties #(.WAKE_CYC(fhb_pkg::WAKE_CYC)) chk (.clk_i, .rst_i,
	.rd_valid_o, .addr_o, .data_lines_o, .data_lines_oe_o, .chip_sel_n_o, .out_en_n_o,
	.write_n_o, .reset_powerdown_n_o);

//--- test/fhb_flash_model.sv
// Behavioural flash part on the host's asynchronous pins
`timescale 1ns/100ps
module fhb_flash_model #(
	parameter int BUSY_NS = 60
) (
	input wire logic [18:0] addr_i,
	input wire logic [7:0] data_lines_i,
	input wire logic chip_sel_n_i,
	input wire logic out_en_n_i,
	input wire logic write_n_i,
	input wire logic reset_powerdown_n_i,
	output logic [7:0] data_lines_o,
	output logic data_lines_oe_o,
	output logic ready_busy_low_o
);
	logic [7:0] mem [0:(1 << 19)-1];
	logic wr_ok;
	realtime woke_at = 0.0;
	logic awake_ok = 1'b0;
	////////////////////////////////////////
	// Array holds a known pattern and starts in read-array mode
	initial begin
		ready_busy_low_o = 1'b0;
		for (int i = 0; i < (1 << 19); i++) mem[i] = i[7:0];
	end
	// An access that opens inside the recovery time finds the part still asleep
	always @(posedge reset_powerdown_n_i) woke_at = $realtime;
	always @(negedge chip_sel_n_i)
		awake_ok = reset_powerdown_n_i && ($realtime - woke_at >= fhb_pkg::WAKE_NS);
	// Drive only when selected, enabled and awake; else show the inverse
	assign data_lines_oe_o = !chip_sel_n_i && !out_en_n_i && write_n_i
		&& reset_powerdown_n_i && awake_ok;
	assign data_lines_o = data_lines_oe_o ? mem[addr_i]
		: ~mem[addr_i];
	assign wr_ok = !chip_sel_n_i && reset_powerdown_n_i && awake_ok;
	// Address and data latch on the strobe's rising edge
	always @(posedge write_n_i) if (wr_ok) mem[addr_i] = data_lines_i;
	// Busy after a write, cut short by reset
	always @(posedge write_n_i) if (wr_ok) begin
		ready_busy_low_o = 1'b1;
		#BUSY_NS ready_busy_low_o = 1'b0;
	end
	always @(negedge reset_powerdown_n_i) ready_busy_low_o = 1'b0;
endmodule : fhb_flash_model

//--- test/tb.sv
// Bench for the flash host controller with a flash model
`timescale 1ns/100ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic powerdown_i = 1'b0;
	logic busy_seen = 1'b0;
	fhb_pkg::fhb_req_s req_i = '0;
	fhb_pkg::fhb_req_s rows [8];
	logic [7:0] exp_rd [8];
	logic [7:0] rd_data, h_dq, m_dq, bus;
	logic [18:0] addr;
	logic rdy, rd_valid, busy, awake, h_oe, cs_n, oe_n, we_n, rp_n, m_busy, rb_n;
	int error_cnt = 0;
	int samples_checked = 0;
	////////////////////////////////////////
	// Clock, shared lines and parts
	always #5 clk_i = ~clk_i;
	assign bus = h_oe ? h_dq : m_dq;
	assign rb_n = !m_busy; // Pull-up on the open-drain line
	always @(posedge clk_i) if (busy === 1'b1) busy_seen <= 1'b1;
	// Recovery time stays at its full length: the model refuses an early access
	fhb_host #(.ACCESS_CYC(3), .STROBE_CYC(2)) dut (.clk_i, .rst_i, .req_valid_i,
		.req_i, .req_ready_o(rdy), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .powerdown_i,
		.busy_o(busy), .awake_o(awake), .addr_o(addr), .data_lines_i(bus), .data_lines_o(h_dq),
		.data_lines_oe_o(h_oe), .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .write_n_o(we_n),
		.reset_powerdown_n_o(rp_n), .ready_busy_n_i(rb_n));
	fhb_flash_model #(.BUSY_NS(3000)) flash (.addr_i(addr), .data_lines_i(bus),
		.chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .write_n_i(we_n), .reset_powerdown_n_i(rp_n),
		.data_lines_o(m_dq), .data_lines_oe_o(), .ready_busy_low_o(m_busy));
	////////////////////////////////////////
	// Compare, request and closing tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic do_req(input fhb_pkg::fhb_req_s r, output logic [7:0] got);
		int n;
		logic taken;
		n = 0;
		req_i <= r;
		req_valid_i <= 1'b1;
		do @(posedge clk_i); while (rdy !== 1'b1 && n++ < 300);
		taken = (rdy === 1'b1);
		req_valid_i <= 1'b0;
		while (!r.write && rd_valid !== 1'b1 && n++ < 600) @(posedge clk_i);
		got = rd_data;
		// A request never taken or never answered counts as a mismatch
		if (!taken || (!r.write && rd_valid !== 1'b1)) begin
			error_cnt++;
			$display("CHECK FAILED handshake expected answer seen none");
		end
		@(posedge clk_i);
	endtask : do_req
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	// Watchdog
	initial begin
		#100000;
		error_cnt++;
		$display("CHECK FAILED watchdog expected finish seen timeout");
		summarize();
	end
	// Reset check, then rows, then power-down case
	initial begin
		logic [7:0] got;
		rows = '{'{1'b1, 5'h1f, 14'h3fff, 8'ha5}, '{1'b0, 5'h1f, 14'h3fff, 8'h00},
			'{1'b1, 5'h00, 14'h0000, 8'h3c}, '{1'b0, 5'h00, 14'h0000, 8'h00},
			'{1'b1, 5'h01, 14'h2000, 8'hc3}, '{1'b0, 5'h01, 14'h2000, 8'h00},
			'{1'b0, 5'h00, 14'h0000, 8'h00}, '{1'b0, 5'h10, 14'h0001, 8'h00}};
		exp_rd = '{8'h00, 8'ha5, 8'h00, 8'h3c, 8'h00, 8'hc3, 8'h3c, 8'h01};
		repeat (4) @(posedge clk_i);
		chk("reset pin", 8'h00, {7'h00, rp_n});
		$display("reset test done");
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			do_req(rows[i], got);
			if (!rows[i].write) chk("read data", exp_rd[i], got);
			$display("row %0d done", i);
		end
		chk("busy flag", 8'h01, {7'h00, busy_seen});
		do_req(fhb_pkg::fhb_req_s'{1'b1, 5'h07, 14'h0123, 8'h96}, got);
		powerdown_i <= 1'b1;
		req_valid_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk("select held off", 8'h01, {7'h00, cs_n});
		chk("ready line", 8'h01, {7'h00, rb_n});
		chk("busy masked", 8'h00, {7'h00, busy});
		chk("asleep flag", 8'h00, {7'h00, awake});
		powerdown_i <= 1'b0;
		do_req(fhb_pkg::fhb_req_s'{1'b0, 5'h07, 14'h0123, 8'h00}, got);
		chk("wake read", 8'h96, got);
		chk("awake flag", 8'h01, {7'h00, awake});
		$display("power-down test done");
		summarize();
	end
endmodule : tb
